// File: src/sosd_pkg.sv
// package for the stop mode and oscillation stop detection block
package sosd_pkg;

  // stop-detect enable field values
  localparam logic [1:0] SOSD_DETECT_ON = 2'h3;
  localparam logic [1:0] SOSD_DETECT_OFF = 2'h0;
  // system clock divider setting forced on stop entry (divide-by-8 select)
  localparam logic SOSD_DIV8_ON = 1'h1;
  // protect register bit positions
  localparam int SOSD_PRC_CLOCK = 0;
  localparam int SOSD_PRC_PROC = 1;
  localparam int SOSD_PRC_PORT0 = 2;
  localparam int SOSD_PRC_VOLT = 3;
  // write group select codes
  localparam logic [1:0] SOSD_GRP_CLOCK = 2'h0;
  localparam logic [1:0] SOSD_GRP_PROC = 2'h1;
  localparam logic [1:0] SOSD_GRP_PORT0 = 2'h2;
  localparam logic [1:0] SOSD_GRP_VOLT = 2'h3;
  // timing: main clock monitor window, 1 us at 200 MHz
  localparam int SOSD_CLK_MHZ = 200;
  localparam int SOSD_WATCH_NS = 1000;
  localparam int SOSD_WATCH_CYC = SOSD_WATCH_NS * SOSD_CLK_MHZ / 1000;
  localparam int SOSD_WATCH_W = 8;
  // prefetch bytes after the stop instruction
  localparam int SOSD_PREFETCH_BYTES = 4;
  localparam logic [2:0] SOSD_PREFETCH_LAST = 3'h4;
  // reset values of clock control bits
  localparam logic SOSD_RST_DIV8 = 1'h1;
  localparam logic SOSD_RST_LOWSTOP = 1'h0;

  // clock control bits held by this block
  typedef struct packed {
    logic all_clock_stop_bit;
    logic divide_by_eight_select;
    logic sub_osc_drive_high;
    logic main_osc_drive_high;
    logic system_clock_select;
    logic main_osc_pin_function;
    logic sub_osc_enable;
    logic periph_clock_stop_in_wait;
    logic main_clock_stop_bit;
    logic low_speed_osc_stop;
  } sosd_clk_ctrl_type;

  // detect register state
  typedef struct packed {
    logic main_clock_stopped_flag;
    logic onchip_osc_selected_flag;
    logic stop_detect_enable_hi;
    logic stop_detect_enable_lo;
  } sosd_detect_type;

  // oscillator pin control: out value and active-low output enable
  typedef struct packed {
    logic main_osc_out;
    logic main_osc_oe_n;
    logic sub_osc_out;
    logic sub_osc_oe_n;
  } sosd_pin_type;

  // power state
  typedef enum logic [1:0] {
    SOSD_RUN,
    SOSD_PREFETCH,
    SOSD_STOP,
    SOSD_WAKE
  } sosd_state_type;

endpackage

// File: src/sosd_clk_monitor.sv
// main clock activity monitor sampled into the system clock domain
module sosd_clk_monitor
  import sosd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic main_clock,
  input wire logic enable,
  output logic clock_lost
);

  logic sync_a;
  logic sync_b;
  logic last;
  logic [SOSD_WATCH_W-1:0] idle_count;
  logic seen_edge;
  logic expired;

  // two flip-flop synchroniser for the main crystal clock
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last <= 1'b0;
    end else begin
      sync_a <= main_clock;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  assign seen_edge = sync_b ^ last;
  assign expired = idle_count == SOSD_WATCH_W'(SOSD_WATCH_CYC);

  // count cycles with no toggle; saturate on a lost clock
  always_ff @(posedge core_clk) begin
    if (!rstn || !enable || seen_edge) begin
      idle_count <= '0;
    end else if (!expired) begin
      idle_count <= idle_count + 1'b1;
    end
  end

  // lost pulse fires once on reaching the window
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clock_lost <= 1'b0;
    end else begin
      clock_lost <= enable && !seen_edge && (idle_count == SOSD_WATCH_W'(SOSD_WATCH_CYC - 1));
    end
  end

endmodule

// File: src/sosd_core.sv
// stop mode control, oscillator pin hold, stop detection and write protection
//
// Overview of operation
// - writing the all-stop bit enters stop
// - stop entry forces divide-by-8 and high drive
// - pins keep their pre-stop state in stop
// - main clock: drive main output high or input
// - sub clock: drive sub output high or input
// - reset or enabled interrupt leaves stop
// - interrupt sequence runs after clock restarts
// - wake resumes at previous clock divided by 8
// - detection active only when field is 11b
// - detected stop sets flags, starts low oscillator, requests
// - stop interrupt shares vector with watchdog, monitors
// - cause flag from stopped flag or enable+selected
// - prefetch four bytes before halting
// - protect bits gate four register groups
module sosd_core
  import sosd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic main_clock,
  input wire logic wr_en,
  input wire logic [1:0] wr_group,
  input wire sosd_clk_ctrl_type wr_clk_ctrl,
  input wire logic [1:0] wr_detect_enable,
  input wire logic wr_protect_en,
  input wire logic [3:0] wr_protect,
  input wire logic prefetch_byte,
  input wire logic wake_irq,
  input wire logic [7:0] pin_out_run,
  input wire logic [7:0] pin_oe_n_run,
  input wire logic watchdog_cause_flag,
  input wire logic monitor1_cause_flag,
  input wire logic monitor2_cause_flag,
  output sosd_clk_ctrl_type clk_ctrl,
  output sosd_detect_type detect,
  output logic [3:0] write_protect_register,
  output logic [3:0] group_write_ok,
  output logic cpu_clock_run,
  output logic cpu_halt,
  output logic irq_sequence_start,
  output logic in_stop,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output sosd_pin_type osc_pins,
  output logic osc_stop_irq,
  output logic shared_vector_irq,
  output logic osc_stop_cause
);

  // ==========================================================
  // write protection
  sosd_state_type state;
  sosd_state_type next_state;
  logic [2:0] prefetch_count;
  logic [7:0] held_out;
  logic [7:0] held_oe_n;
  logic clock_lost;
  logic detect_on;
  logic detect_hit;
  logic clock_wr;
  logic stop_req;
  logic prefetch_done;
  logic wake_now;

  // a group write passes only while its protect bit is 1
  assign group_write_ok = write_protect_register;
  assign clock_wr = wr_en && wr_group == SOSD_GRP_CLOCK
    && write_protect_register[SOSD_PRC_CLOCK];

  // protect register itself is always writable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      write_protect_register <= 4'h0;
    end else if (wr_protect_en) begin
      write_protect_register <= wr_protect;
    end
  end

  // ==========================================================
  // stop mode sequencing
  assign stop_req = clock_wr && wr_clk_ctrl.all_clock_stop_bit;
  assign prefetch_done = prefetch_byte
    && prefetch_count == SOSD_PREFETCH_LAST - 3'h1;
  assign wake_now = wake_irq;

  // next state decode
  always_comb begin
    next_state = state;
    case (state)
      SOSD_RUN: begin
        if (stop_req) begin
          next_state = SOSD_PREFETCH;
        end
      end
      SOSD_PREFETCH: begin
        if (prefetch_done) begin
          next_state = SOSD_STOP;
        end
      end
      SOSD_STOP: begin
        if (wake_now) begin
          next_state = SOSD_WAKE;
        end
      end
      SOSD_WAKE: begin
        next_state = SOSD_RUN;
      end
      default: begin
        next_state = SOSD_RUN;
      end
    endcase
  end

  // state and prefetch byte counter
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= SOSD_RUN;
      prefetch_count <= 3'h0;
    end else begin
      state <= next_state;
      if (state != SOSD_PREFETCH) begin
        prefetch_count <= 3'h0;
      end else if (prefetch_byte) begin
        prefetch_count <= prefetch_count + 3'h1;
      end
    end
  end

  assign in_stop = state == SOSD_STOP;
  assign cpu_halt = state == SOSD_STOP || state == SOSD_PREFETCH && prefetch_done;
  assign cpu_clock_run = state != SOSD_STOP;
  // interrupt sequence once clock supply is back
  assign irq_sequence_start = state == SOSD_WAKE;

  // ==========================================================
  // clock control bits
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clk_ctrl <= '0;
      clk_ctrl.divide_by_eight_select <= SOSD_RST_DIV8;
      clk_ctrl.low_speed_osc_stop <= SOSD_RST_LOWSTOP;
    end else begin
      if (clock_wr) begin
        clk_ctrl <= wr_clk_ctrl;
      end
      if (stop_req) begin
        clk_ctrl.divide_by_eight_select <= SOSD_DIV8_ON;
        clk_ctrl.sub_osc_drive_high <= 1'b1;
        clk_ctrl.main_osc_drive_high <= 1'b1;
      end
      if (state == SOSD_WAKE) begin
        clk_ctrl.all_clock_stop_bit <= 1'b0;
      end
      if (detect_hit) begin
        clk_ctrl.low_speed_osc_stop <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pin hold in stop
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      held_out <= 8'h00;
      held_oe_n <= 8'hFF;
    end else if (state != SOSD_STOP) begin
      held_out <= pin_out_run;
      held_oe_n <= pin_oe_n_run;
    end
  end

  assign pin_out = in_stop ? held_out : pin_out_run;
  assign pin_oe_n = in_stop ? held_oe_n : pin_oe_n_run;

  // oscillator pins: driven high or released as input in stop
  always_comb begin
    osc_pins = '0;
    osc_pins.main_osc_oe_n = 1'b1;
    osc_pins.sub_osc_oe_n = 1'b1;
    if (in_stop && !clk_ctrl.system_clock_select) begin
      osc_pins.main_osc_out = clk_ctrl.main_osc_pin_function;
      osc_pins.main_osc_oe_n = !clk_ctrl.main_osc_pin_function;
    end
    if (in_stop && clk_ctrl.system_clock_select) begin
      osc_pins.sub_osc_out = clk_ctrl.sub_osc_enable;
      osc_pins.sub_osc_oe_n = !clk_ctrl.sub_osc_enable;
    end
  end

  // ==========================================================
  // oscillation stop detection
  assign detect_on = {detect.stop_detect_enable_hi, detect.stop_detect_enable_lo}
    == SOSD_DETECT_ON;

  sosd_clk_monitor u_mon (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clock(main_clock),
    .enable(detect_on && !clk_ctrl.system_clock_select && !in_stop),
    .clock_lost(clock_lost)
  );

  assign detect_hit = clock_lost && detect_on && !clk_ctrl.system_clock_select;

  // flags: detection wins over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      detect <= '0;
    end else begin
      if (clock_wr) begin
        detect.stop_detect_enable_hi <= wr_detect_enable[1];
        detect.stop_detect_enable_lo <= wr_detect_enable[0];
        detect.onchip_osc_selected_flag <= 1'b0;
        detect.main_clock_stopped_flag <= 1'b0;
      end
      if (detect_hit) begin
        detect.onchip_osc_selected_flag <= 1'b1;
        detect.main_clock_stopped_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      osc_stop_irq <= 1'b0;
    end else begin
      osc_stop_irq <= detect_hit;
    end
  end

  // cause decode and shared vector
  assign osc_stop_cause = detect.main_clock_stopped_flag
    || detect_on && detect.onchip_osc_selected_flag;
  assign shared_vector_irq = osc_stop_irq || watchdog_cause_flag
    || monitor1_cause_flag || monitor2_cause_flag;

endmodule

// File: sim/sosd_core_properties.sv
// checker for stop mode, oscillator pins and stop detection
module sosd_core_properties
  import sosd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [1:0] wr_group,
  input wire logic wake_irq,
  input wire logic watchdog_cause_flag,
  input wire logic monitor1_cause_flag,
  input wire logic monitor2_cause_flag,
  input wire sosd_clk_ctrl_type clk_ctrl,
  input wire sosd_detect_type detect,
  input wire logic [3:0] write_protect_register,
  input wire logic cpu_clock_run,
  input wire logic irq_sequence_start,
  input wire logic in_stop,
  input wire sosd_pin_type osc_pins,
  input wire logic osc_stop_irq,
  input wire logic shared_vector_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========
  // shorthand views
  wire logic [1:0] en_field = {detect.stop_detect_enable_hi, detect.stop_detect_enable_lo};
  wire logic sys_sel = clk_ctrl.system_clock_select;
  wire logic m_fn = clk_ctrl.main_osc_pin_function;
  wire logic s_en = clk_ctrl.sub_osc_enable;
  sequence s_forced;
    clk_ctrl.divide_by_eight_select && clk_ctrl.sub_osc_drive_high && clk_ctrl.main_osc_drive_high;
  endsequence
  sequence s_woken;
    irq_sequence_start && !in_stop && clk_ctrl.divide_by_eight_select;
  endsequence
  a_stop_forces_div: assert property ($rose(clk_ctrl.all_clock_stop_bit) |-> s_forced)
    else $error("stop entry without forced bits");
  a_stop_halts: assert property (in_stop |-> !cpu_clock_run)
    else $error("cpu clock runs in stop");
  a_wake_order: assert property (in_stop && wake_irq |=> s_woken)
    else $error("wake sequence wrong");
  a_main_osc_pin: assert property (in_stop && !sys_sel |->
    osc_pins.main_osc_oe_n == !m_fn && (osc_pins.main_osc_out || !m_fn))
    else $error("main osc pin wrong in stop");
  a_sub_osc_pin: assert property (in_stop && sys_sel |->
    osc_pins.sub_osc_oe_n == !s_en && (osc_pins.sub_osc_out || !s_en))
    else $error("sub osc pin wrong in stop");
  a_irq_needs_enable: assert property (osc_stop_irq |->
    $past(en_field) == SOSD_DETECT_ON && !$past(sys_sel))
    else $error("stop irq while detection off");
  a_detect_flags_set: assert property (osc_stop_irq |-> detect.main_clock_stopped_flag
    && detect.onchip_osc_selected_flag && !clk_ctrl.low_speed_osc_stop)
    else $error("flags not set after stop irq");
  a_shared_vector_or: assert property (shared_vector_irq == (osc_stop_irq
    || watchdog_cause_flag || monitor1_cause_flag || monitor2_cause_flag))
    else $error("shared vector mismatch");
  a_protect_blocks: assert property (wr_en && wr_group == SOSD_GRP_CLOCK
    && !write_protect_register[SOSD_PRC_CLOCK] |=> $stable(en_field))
    else $error("protected write landed");
endmodule
bind sosd_core sosd_core_properties u_props (.core_clk, .rstn, .wr_en, .wr_group, .wake_irq,
  .watchdog_cause_flag, .monitor1_cause_flag, .monitor2_cause_flag, .clk_ctrl, .detect,
  .write_protect_register, .cpu_clock_run, .irq_sequence_start, .in_stop, .osc_pins,
  .osc_stop_irq, .shared_vector_irq);

// File: sim/sosd_core_tb.sv
// testbench for the stop mode and oscillation stop detection block
module sosd_core_tb
  import sosd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, rstn = 1'h0, main_clock = 1'h0, main_run = 1'h1;
  logic wr_en = 1'h0, wr_protect_en = 1'h0, prefetch_byte = 1'h0, wake_irq = 1'h0;
  logic [1:0] wr_group = 2'h0, wr_detect_enable = 2'h0;
  logic [2:0] causes = 3'h0;
  logic [3:0] wr_protect = 4'h0, write_protect_register, group_write_ok;
  logic [7:0] pin_out_run = 8'h00, pin_oe_n_run = 8'h0F, pin_out, pin_oe_n;
  sosd_clk_ctrl_type wr_clk_ctrl = '0, clk_ctrl;
  sosd_detect_type detect;
  sosd_pin_type osc_pins;
  logic cpu_clock_run, cpu_halt, irq_sequence_start, in_stop;
  logic osc_stop_irq, shared_vector_irq, osc_stop_cause;
  int fails = 0, tests_run = 0;
  // ==========
  // clocks: main crystal stops when main_run drops
  always #2.5 core_clk = ~core_clk;
  always #7 if (main_run) main_clock = ~main_clock;
  sosd_core dut (.core_clk, .rstn, .main_clock, .wr_en, .wr_group, .wr_clk_ctrl,
    .wr_detect_enable, .wr_protect_en, .wr_protect, .prefetch_byte, .wake_irq, .pin_out_run,
    .pin_oe_n_run, .watchdog_cause_flag(causes[2]), .monitor1_cause_flag(causes[1]),
    .monitor2_cause_flag(causes[0]), .clk_ctrl, .detect, .write_protect_register,
    .group_write_ok, .cpu_clock_run, .cpu_halt, .irq_sequence_start, .in_stop, .pin_out,
    .pin_oe_n, .osc_pins, .osc_stop_irq, .shared_vector_irq, .osc_stop_cause);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_clk(input sosd_clk_ctrl_type c, input logic [1:0] d);
    wr_en = 1'h1;
    wr_clk_ctrl = c;
    wr_detect_enable = d;
    tick();
    wr_en = 1'h0;
    tick();
  endtask
  task automatic prot(input logic [3:0] p);
    wr_protect_en = 1'h1;
    wr_protect = p;
    tick();
    wr_protect_en = 1'h0;
  endtask
  task automatic t_protect();
    sosd_clk_ctrl_type c;
    c = '0;
    c.sub_osc_enable = 1'h1;
    chk("clk_ctrl", 16'h0100, 16'(clk_ctrl));
    wr_clk(c, SOSD_DETECT_ON);
    chk("detect", 16'h0000, 16'(detect));
    prot(4'hE);
    chk("protect", 16'h000E, 16'(group_write_ok));
    chk("protect_reg", 16'h000E, 16'(write_protect_register));
    wr_clk(c, SOSD_DETECT_OFF);
    chk("clk_ctrl", 16'h0100, 16'(clk_ctrl));
    prot(4'hF);
    wr_clk(c, SOSD_DETECT_OFF);
    chk("clk_ctrl", 16'h0008, 16'(clk_ctrl));
  endtask
  task automatic t_stop(input logic sel, input logic fe);
    sosd_clk_ctrl_type c;
    logic [1:0] o;
    c = '0;
    c.all_clock_stop_bit = 1'h1;
    c.system_clock_select = sel;
    c.main_osc_pin_function = fe;
    c.sub_osc_enable = fe;
    pin_out_run = 8'hA5;
    pin_oe_n_run = 8'h0F;
    wr_en = 1'h1;
    wr_clk_ctrl = c;
    wr_detect_enable = SOSD_DETECT_OFF;
    tick();
    wr_en = 1'h0;
    prefetch_byte = 1'h1;
    tick(3);
    chk("in_stop", 16'h0000, 16'(in_stop));
    chk("cpu_halt", 16'h0001, 16'(cpu_halt));
    tick();
    prefetch_byte = 1'h0;
    tick();
    chk("in_stop", 16'h0001, 16'(in_stop));
    chk("cpu_clock_run", 16'h0000, 16'(cpu_clock_run));
    chk("forced", 16'h0007, 16'(clk_ctrl[8:6]));
    chk("cpu_halt", 16'h0001, 16'(cpu_halt));
    pin_out_run = 8'h5A;
    pin_oe_n_run = 8'hF0;
    tick();
    chk("pin_out", 16'h00A5, 16'(pin_out));
    chk("pin_oe_n", 16'h000F, 16'(pin_oe_n));
    o = sel ? {osc_pins.sub_osc_out, osc_pins.sub_osc_oe_n}
      : {osc_pins.main_osc_out, osc_pins.main_osc_oe_n};
    chk("osc_pins", {14'h0, fe, !fe}, {14'h0, fe & o[1], o[0]});
    wake_irq = 1'h1;
    tick();
    chk("irq_seq", 16'h0001, 16'(irq_sequence_start));
    wake_irq = 1'h0;
    tick();
    chk("wake_ctrl", 16'h0001, {14'h0, clk_ctrl[9:8]});
    chk("pin_out", 16'h005A, 16'(pin_out));
    chk("cpu_clock_run", 16'h0001, 16'(cpu_clock_run));
  endtask
  task automatic t_detect(input logic [1:0] d, input logic sel, input logic exp);
    sosd_clk_ctrl_type c;
    logic hit;
    c = '0;
    c.low_speed_osc_stop = 1'h1;
    c.system_clock_select = sel;
    hit = 1'h0;
    wr_clk(c, d);
    main_run = 1'h0;
    for (int i = 0; i < 300 && !hit; i++) begin
      tick();
      hit = osc_stop_irq === 1'h1;
    end
    chk("osc_stop_irq", {15'h0, exp}, {15'h0, hit});
    if (hit) begin
      chk("shared_irq", 16'h0001, 16'(shared_vector_irq));
      tick();
      chk("flags", 16'h000F, 16'(detect));
      chk("low_osc_stop", 16'h0000, 16'(clk_ctrl.low_speed_osc_stop));
      chk("cause", 16'h0001, 16'(osc_stop_cause));
    end
    main_run = 1'h1;
    wr_clk(c, SOSD_DETECT_OFF);
    chk("cause", 16'h0000, 16'(osc_stop_cause));
  endtask
  task automatic t_cause();
    for (int i = 0; i < 4; i++) begin
      causes = 3'h4 >> i;
      tick();
      chk("shared_irq", {15'h0, i < 3}, 16'(shared_vector_irq));
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    tick(12);
    rstn = 1'h1;
    tick();
    t_protect();
    for (int i = 0; i < 4; i++) t_stop(i[1], i[0]);
    t_detect(SOSD_DETECT_ON, 1'h0, 1'h1);
    t_detect(2'h1, 1'h0, 1'h0);
    t_detect(SOSD_DETECT_ON, 1'h1, 1'h0);
    t_cause();
    wrap_up();
  end
  initial begin
    #30000;
    fails++;
    wrap_up();
  end
endmodule
